//--- src/latc_pkg.sv
package latc_pkg;

  // ---------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------
  // Sample width and buffer address width (1024 samples)
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 10;
  // Zero address: reset value of the write offset and counters
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 10'h000;

  // ---------------------------------------------------------------
  // Status, Gray coded along idle-pre-wait-post-full
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_pre = 3'h1,
    st_wait = 3'h3,
    st_post = 3'h2,
    st_full = 3'h6
  } latc_state_t;

  // Trigger source selection
  typedef enum logic [2:0] {
    basic_only_mode = 3'h0,
    advanced_only_mode = 3'h1,
    basic_or_external_mode = 3'h2,
    advanced_or_external_mode = 3'h3,
    external_only_mode = 3'h4
  } latc_trig_mode_t;

  // Cross-trigger output behaviour
  typedef enum logic [1:0] {
    out_disabled = 2'h0,
    out_trigger_only = 2'h1,
    out_input_only = 2'h2,
    out_follows_either = 2'h3
  } latc_out_mode_t;

  // Sample qualification
  typedef enum logic {
    cap_always = 1'b0,
    cap_qualified = 1'b1
  } latc_cap_mode_t;

  // Global combining of comparator results
  typedef enum logic [1:0] {
    comb_and = 2'h0,
    comb_or = 2'h1,
    comb_nand = 2'h2,
    comb_nor = 2'h3
  } latc_comb_t;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  // Static configuration from the debug host
  typedef struct packed {
    latc_trig_mode_t trig_mode;
    latc_out_mode_t out_mode;
    latc_cap_mode_t cap_mode;
    latc_comb_t trig_comb;
    latc_comb_t cap_comb;
    logic [ADDR_W-1:0] trig_pos;
    logic [3:0] depth_log2;
    logic [3:0] wins_log2;
  } latc_cfg_t;

  // One stored sample with its buffer address
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } latc_word_t;

endpackage

//--- src/latc_trigger_capture.sv
// Function
// - Optional cross-trigger input and output with acknowledges
// - Cross input ORed with basic or advanced
// - External-only mode fires on input rising edge
// - Output mode: off, trigger, input, either
// - Store samples only in pre, wait, post
// - Unconditional mode stores every capturing cycle with room in the sample buffer
// - Qualified mode stores only when condition true
// - Capture condition has own comparators and combine
// - Combine functions AND, OR, NAND, NOR
// - Buffer split into equal power-of-two windows
// - Separate trigger mark for every window
// - Stop halts, filled windows stay available
// - Position zero re-arms on next cycle
// - Nonzero position pre-fills before accepting trigger
// - Default advanced program triggers at once
// - Arm enters wait or pre by position
module latc_trigger_capture #(
  parameter int unsigned PROBE_N = 8,
  parameter int unsigned MAX_WIN_LOG2 = 4,
  parameter bit EN_CROSS_TRIGGER_INPUT = 1'b1,
  parameter bit EN_CROSS_TRIGGER_OUTPUT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire latc_pkg::latc_cfg_t cfg,
  input wire logic arm_req,
  input wire logic stop_req,
  input wire logic [PROBE_N-1:0] trig_cmp,
  input wire logic [PROBE_N-1:0] trig_part,
  input wire logic [PROBE_N-1:0] cap_cmp,
  input wire logic [PROBE_N-1:0] cap_part,
  input wire logic adv_trig,
  input wire logic adv_prog_loaded,
  input wire logic [latc_pkg::DATA_W-1:0] sample,
  input wire logic cross_trigger_input,
  output logic cross_trigger_input_ack,
  output logic cross_trigger_output,
  input wire logic cross_trigger_output_ack,
  output latc_pkg::latc_word_t wr_word,
  output logic wr_valid,
  input wire logic wr_ready,
  input wire logic [MAX_WIN_LOG2-1:0] mark_sel,
  output logic [latc_pkg::ADDR_W-1:0] mark_addr,
  output latc_pkg::latc_state_t status,
  output logic buffer_full,
  output logic [MAX_WIN_LOG2:0] windows_filled
);

  localparam int unsigned AW = latc_pkg::ADDR_W;
  localparam int unsigned WW = MAX_WIN_LOG2 + 1;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Global combine of participating comparators
  function automatic logic combine(input logic [PROBE_N-1:0] cmp,
                                   input logic [PROBE_N-1:0] part,
                                   input latc_pkg::latc_comb_t sel);
    logic r;
    r = 1'b0;
    case (sel)
      latc_pkg::comb_and: r = &(cmp | ~part);
      latc_pkg::comb_or: r = |(cmp & part);
      latc_pkg::comb_nand: r = |(~cmp & part);
      latc_pkg::comb_nor: r = &(~cmp | ~part);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Synchronisers for host commands and cross-trigger pins
  // ---------------------------------------------------------------
  logic [3:0] sync1; // First stage, read only by sync2
  logic [3:0] sync2; // Stable copies: arm, stop, xin, xack
  logic [3:0] sync_d; // Previous stable value for edges
  logic arm_pulse;
  logic stop_pulse;
  logic ext_lvl;
  logic ext_rise;
  logic oack_rise;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync_d <= 4'h0;
    end
    else
    begin
      sync1 <= {cross_trigger_output_ack, cross_trigger_input, stop_req, arm_req};
      sync2 <= sync1;
      sync_d <= sync2;
    end
  end

  // Commands act on their rising edge only
  assign arm_pulse = sync2[0] & ~sync_d[0];
  assign stop_pulse = sync2[1] & ~sync_d[1];
  assign ext_lvl = EN_CROSS_TRIGGER_INPUT & sync2[2];
  assign ext_rise = ext_lvl & ~sync_d[2];
  assign oack_rise = sync2[3] & ~sync_d[3];

  // ---------------------------------------------------------------
  // Trigger and capture conditions
  // ---------------------------------------------------------------
  logic basic_hit;
  logic adv_hit;
  logic trig_hit;
  logic cap_hit;

  always_comb
  begin
    basic_hit = combine(trig_cmp, trig_part, cfg.trig_comb);
    adv_hit = adv_prog_loaded ? adv_trig : 1'b1;
    cap_hit = combine(cap_cmp, cap_part, cfg.cap_comb);
    case (cfg.trig_mode)
      latc_pkg::basic_only_mode: trig_hit = basic_hit;
      latc_pkg::advanced_only_mode: trig_hit = adv_hit;
      latc_pkg::basic_or_external_mode: trig_hit = basic_hit | ext_lvl;
      latc_pkg::advanced_or_external_mode: trig_hit = adv_hit | ext_lvl;
      latc_pkg::external_only_mode: trig_hit = ext_rise;
      default: trig_hit = basic_hit;
    endcase
  end

  // ---------------------------------------------------------------
  // Window geometry
  // ---------------------------------------------------------------
  logic [3:0] wl; // Window count log2, clamped
  logic [3:0] dl; // Window depth log2, clamped
  logic [AW-1:0] mask; // Offset mask inside a window
  logic [AW-1:0] pos; // Trigger position inside a window
  logic [AW:0] post_need; // Stores from trigger sample to end
  logic [WW-1:0] nwin;

  always_comb
  begin
    wl = (cfg.wins_log2 > 4'(MAX_WIN_LOG2)) ? 4'(MAX_WIN_LOG2) : cfg.wins_log2;
    dl = (cfg.depth_log2 > 4'(AW) - wl) ? 4'(AW) - wl : cfg.depth_log2;
    mask = AW'((AW+1)'(1) << dl) - AW'(1);
    pos = cfg.trig_pos & mask;
    post_need = {1'b0, mask} - {1'b0, pos} + (AW+1)'(1);
    nwin = WW'(1) << wl;
  end

  // ---------------------------------------------------------------
  // Capture sequencer
  // ---------------------------------------------------------------
  latc_pkg::latc_state_t state; // Current status
  latc_pkg::latc_state_t next_state;
  logic [AW-1:0] ptr; // Write offset in window
  logic [AW-1:0] next_ptr;
  logic [AW-1:0] cnt; // Pre-trigger samples stored
  logic [AW-1:0] next_cnt;
  logic [AW:0] rem; // Post-trigger stores still owed
  logic [AW:0] next_rem;
  logic [WW-1:0] win; // Windows completely filled
  logic [WW-1:0] next_win;
  logic capturing;
  logic store;
  logic fire;
  logic win_done;
  logic in_ready; // Room in the output buffer
  logic [AW-1:0] ptr_inc;

  assign capturing = (state == latc_pkg::st_pre) || (state == latc_pkg::st_wait) ||
                     (state == latc_pkg::st_post);
  // qualification; a full buffer stalls storing
  assign store = capturing && in_ready &&
                 ((cfg.cap_mode == latc_pkg::cap_always) || cap_hit);
  assign fire = (state == latc_pkg::st_wait) && trig_hit;
  assign ptr_inc = (ptr + AW'(1)) & mask;

  always_comb
  begin
    next_state = state;
    next_ptr = ptr;
    next_cnt = cnt;
    next_rem = rem;
    next_win = win;
    win_done = 1'b0;
    case (state)
      latc_pkg::st_idle, latc_pkg::st_full:
      begin
        if (arm_pulse)
        begin
          next_ptr = latc_pkg::ADDR_ZERO;
          next_cnt = latc_pkg::ADDR_ZERO;
          next_win = '0;
          next_state = (pos == latc_pkg::ADDR_ZERO) ? latc_pkg::st_wait : latc_pkg::st_pre;
        end
      end
      latc_pkg::st_pre:
      begin
        if (store)
        begin
          next_ptr = ptr_inc;
          next_cnt = cnt + AW'(1);
          if (cnt + AW'(1) == pos)
            next_state = latc_pkg::st_wait;
        end
      end
      latc_pkg::st_wait:
      begin
        // Pre-trigger region wraps until the trigger
        if (store)
          next_ptr = ptr_inc;
        if (fire)
        begin
          next_rem = post_need - (AW+1)'(store);
          if (next_rem == '0)
            win_done = 1'b1;
          else
            next_state = latc_pkg::st_post;
        end
      end
      latc_pkg::st_post:
      begin
        if (store)
        begin
          next_ptr = ptr_inc;
          next_rem = rem - (AW+1)'(1);
          if (rem == (AW+1)'(1))
            win_done = 1'b1;
        end
      end
      default: next_state = latc_pkg::st_idle;
    endcase
    if (win_done)
    begin
      next_win = win + WW'(1);
      next_ptr = latc_pkg::ADDR_ZERO;
      next_cnt = latc_pkg::ADDR_ZERO;
      // re-arm next cycle, full after last
      if (win + WW'(1) == nwin)
        next_state = latc_pkg::st_full;
      else
        next_state = (pos == latc_pkg::ADDR_ZERO) ? latc_pkg::st_wait : latc_pkg::st_pre;
    end
    // stop halts; filled count is kept
    if (stop_pulse && capturing)
    begin
      next_state = latc_pkg::st_idle;
      next_win = win;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= latc_pkg::st_idle;
      ptr <= latc_pkg::ADDR_ZERO;
      cnt <= latc_pkg::ADDR_ZERO;
      rem <= '0;
      win <= '0;
    end
    else
    begin
      state <= next_state;
      ptr <= next_ptr;
      cnt <= next_cnt;
      rem <= next_rem;
      win <= next_win;
    end
  end

  assign status = state;
  assign buffer_full = (state == latc_pkg::st_full);
  assign windows_filled = win;

  // ---------------------------------------------------------------
  // Trigger marks, one per window
  // ---------------------------------------------------------------
  // Not reset: a mark is meaningful only for a filled window
  logic [AW-1:0] mark_mem [2**MAX_WIN_LOG2];
  logic [AW-1:0] win_base;

  assign win_base = AW'(AW'(win[MAX_WIN_LOG2-1:0]) << dl);

  always_ff @(posedge clk_sys)
  begin
    if (fire)
      mark_mem[win[MAX_WIN_LOG2-1:0]] <= win_base | ptr;
  end

  // Registered read port for upload
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      mark_addr <= latc_pkg::ADDR_ZERO;
    else
      mark_addr <= mark_mem[mark_sel];
  end

  // ---------------------------------------------------------------
  // Two-entry sample buffer
  // ---------------------------------------------------------------
  latc_pkg::latc_word_t buf_mem [2];
  logic buf_wp;
  logic buf_rp;
  logic [1:0] buf_cnt;
  logic pop;

  assign in_ready = (buf_cnt != 2'h2);
  assign wr_valid = (buf_cnt != 2'h0);
  assign wr_word = buf_mem[buf_rp];
  assign pop = wr_valid && wr_ready;

  // Pointers and occupancy; receiver stall fills it
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'h0;
    end
    else
    begin
      buf_wp <= buf_wp ^ store;
      buf_rp <= buf_rp ^ pop;
      buf_cnt <= buf_cnt + 2'(store) - 2'(pop);
    end
  end

  // Storage holds data only, no reset needed
  always_ff @(posedge clk_sys)
  begin
    if (store)
      buf_mem[buf_wp] <= '{addr: win_base | ptr, data: sample};
  end

  // ---------------------------------------------------------------
  // Cross-trigger handshakes
  // ---------------------------------------------------------------
  logic in_ack;
  logic next_in_ack;
  logic xout;
  logic next_xout;
  logic out_ev;

  always_comb
  begin
    next_in_ack = ext_lvl;
    case (cfg.out_mode)
      latc_pkg::out_disabled: out_ev = 1'b0;
      latc_pkg::out_trigger_only: out_ev = fire;
      latc_pkg::out_input_only: out_ev = ext_rise;
      latc_pkg::out_follows_either: out_ev = fire | ext_rise;
      default: out_ev = 1'b0;
    endcase
    // hold until ack; a new event wins
    if (out_ev)
      next_xout = 1'b1;
    else if (oack_rise)
      next_xout = 1'b0;
    else
      next_xout = xout;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      in_ack <= 1'b0;
      xout <= 1'b0;
    end
    else
    begin
      in_ack <= next_in_ack;
      xout <= next_xout;
    end
  end

  assign cross_trigger_input_ack = EN_CROSS_TRIGGER_INPUT & in_ack;
  assign cross_trigger_output = EN_CROSS_TRIGGER_OUTPUT & xout;

endmodule // latc_trigger_capture

//--- verification/latc_trigger_capture_monitor.sv
module latc_trigger_capture_monitor #(
  parameter int unsigned MAX_WIN_LOG2 = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire latc_pkg::latc_cfg_t cfg,
  input wire logic arm_req,
  input wire logic stop_req,
  input wire logic cross_trigger_input,
  input wire logic cross_trigger_input_ack,
  input wire logic cross_trigger_output,
  input wire logic cross_trigger_output_ack,
  input wire latc_pkg::latc_word_t wr_word,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire latc_pkg::latc_state_t status,
  input wire logic buffer_full,
  input wire logic [MAX_WIN_LOG2:0] windows_filled
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Host arm seen while not capturing
  sequence s_arm;
    $rose(arm_req) ##0 (status == latc_pkg::st_idle || status == latc_pkg::st_full);
  endsequence
  // Host stop seen while capturing
  sequence s_stop;
    $rose(stop_req) ##0 (status inside {latc_pkg::st_pre, latc_pkg::st_wait, latc_pkg::st_post});
  endsequence
  // Output pending with no ack seen for three samples
  sequence s_out_unacked;
    cross_trigger_output && !cross_trigger_output_ack && !$past(cross_trigger_output_ack)
      && !$past(cross_trigger_output_ack, 2);
  endsequence
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_ARM_ZERO: assert property (s_arm ##0 cfg.trig_pos == 10'h000 |-> ##[2:5] status == latc_pkg::st_wait)
    else $error("arm with position zero did not reach wait");
  AST_ARM_PRE: assert property (s_arm ##0 cfg.trig_pos != 10'h000 |-> ##[2:5] status == latc_pkg::st_pre)
    else $error("arm with nonzero position did not reach pre");
  AST_STOP: assert property (s_stop |-> ##[2:5] status == latc_pkg::st_idle)
    else $error("stop did not halt capture");
  AST_NO_STORE: assert property (status == latc_pkg::st_idle && $past(status) == latc_pkg::st_idle && !$past(wr_valid) |-> !wr_valid)
    else $error("word stored outside capture");
  AST_HOLD: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
    else $error("buffered word lost under stall");
  AST_FULL: assert property ($rose(buffer_full) |-> windows_filled == ((MAX_WIN_LOG2+1)'(1) << cfg.wins_log2))
    else $error("full flagged before the last window");
  AST_IN_ACK: assert property (cross_trigger_input_ack == $past(cross_trigger_input, 3))
    else $error("input ack not three cycles after input");
  AST_OUT_HOLD: assert property (s_out_unacked |=> cross_trigger_output)
    else $error("output dropped before ack");
  AST_OUT_OFF: assert property ($rose(cross_trigger_output) |-> cfg.out_mode != latc_pkg::out_disabled)
    else $error("output fired while disabled");
  AST_WIN_STEP: assert property ($changed(windows_filled) |-> windows_filled == 0 || windows_filled == $past(windows_filled) + 1'b1)
    else $error("window count jumped");
endmodule // latc_trigger_capture_monitor

bind latc_trigger_capture latc_trigger_capture_monitor #(.MAX_WIN_LOG2(MAX_WIN_LOG2)) latc_trigger_capture_monitor_inst (
  .clk_sys, .nrst, .cfg, .arm_req, .stop_req, .cross_trigger_input, .cross_trigger_input_ack,
  .cross_trigger_output, .cross_trigger_output_ack, .wr_word, .wr_valid, .wr_ready, .status,
  .buffer_full, .windows_filled);

//--- verification/latc_far_side.sv
module latc_far_side (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic fire_req,
  input wire logic stall,
  input wire logic wr_valid,
  input wire latc_pkg::latc_word_t wr_word,
  input wire logic cross_trigger_input_ack,
  input wire logic cross_trigger_output,
  output logic cross_trigger_input,
  output logic cross_trigger_output_ack,
  output logic wr_ready,
  output int word_count,
  output latc_pkg::latc_word_t last_word
);
  timeunit 1ns;
  timeprecision 100ps;
  // Neighbour core and buffer sink, changing just after each edge
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cross_trigger_input <= 1'b0;
      cross_trigger_output_ack <= 1'b0;
      wr_ready <= 1'b0;
      word_count <= 0;
    end
    else
    begin
      if (fire_req && !cross_trigger_input)
        cross_trigger_input <= #1 1'b1;
      else if (cross_trigger_input_ack)
        cross_trigger_input <= #1 1'b0;
      cross_trigger_output_ack <= #1 cross_trigger_output;
      // Stall only on request, so a buffer fill is provoked
      wr_ready <= #1 !stall;
      if (wr_valid && wr_ready)
      begin
        word_count <= #1 word_count + 1;
        last_word <= #1 wr_word;
      end
    end
  end
endmodule // latc_far_side

//--- verification/latc_trigger_capture_test.sv
module latc_trigger_capture_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  latc_pkg::latc_cfg_t cfg = '0;
  logic arm_req = 1'b0;
  logic stop_req = 1'b0;
  logic [7:0] trig_cmp = 8'h01;
  logic [7:0] trig_part = 8'h01;
  logic [7:0] cap_cmp = 8'h01;
  logic [7:0] cap_part = 8'h01;
  logic adv_prog_loaded = 1'b0;
  logic adv_trig = 1'b0;
  logic [31:0] sample = 32'h0000_0000;
  logic [3:0] mark_sel = 4'h0;
  logic fire_req = 1'b0;
  logic stall = 1'b0;
  logic out_seen = 1'b0;
  logic xin, xin_ack, xout, xout_ack, wr_valid, wr_ready, buffer_full;
  latc_pkg::latc_word_t wr_word, last_word;
  logic [9:0] mark_addr;
  latc_pkg::latc_state_t status;
  logic [4:0] windows_filled;
  int word_count, base;
  int err_count = 0;
  int num_checks = 0;
  // Clock, 10 ns period
  initial forever #5 clk_sys = ~clk_sys;
  // Probed data changes every cycle; output events remembered
  always @(posedge clk_sys)
  begin
    sample <= #1 sample + 32'h0000_0001;
    if (xout)
      out_seen <= 1'b1;
  end
  latc_trigger_capture latc_trigger_capture_inst (.clk_sys(clk_sys), .nrst(nrst), .cfg(cfg),
    .arm_req(arm_req), .stop_req(stop_req), .trig_cmp(trig_cmp), .trig_part(trig_part),
    .cap_cmp(cap_cmp), .cap_part(cap_part), .adv_trig(adv_trig), .adv_prog_loaded(adv_prog_loaded),
    .sample(sample), .cross_trigger_input(xin), .cross_trigger_input_ack(xin_ack),
    .cross_trigger_output(xout), .cross_trigger_output_ack(xout_ack), .wr_word(wr_word),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .mark_sel(mark_sel), .mark_addr(mark_addr),
    .status(status), .buffer_full(buffer_full), .windows_filled(windows_filled));
  latc_far_side latc_far_side_inst (.clk_sys(clk_sys), .nrst(nrst), .fire_req(fire_req),
    .stall(stall), .wr_valid(wr_valid), .wr_word(wr_word), .cross_trigger_input_ack(xin_ack),
    .cross_trigger_output(xout), .cross_trigger_input(xin), .cross_trigger_output_ack(xout_ack),
    .wr_ready(wr_ready), .word_count(word_count), .last_word(last_word));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task step();
    @(posedge clk_sys);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Level pulses two cycles wide, two apart; by reference so the pin moves at once
  task automatic pulse(ref logic s);
    s = 1'b1;
    repeat (2) step();
    s = 1'b0;
    repeat (2) step();
  endtask
  // Bounded wait for full, then let the buffer drain
  task run(input int n, input logic exp);
    base = word_count;
    pulse(arm_req);
    for (int i = 0; i < n && buffer_full !== 1'b1; i++)
      step();
    repeat (4) step();
    chk(buffer_full, exp);
  endtask
  task halt();
    pulse(stop_req);
    repeat (2) step();
    chk(status, latc_pkg::st_idle);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_basic();
    cfg.out_mode = latc_pkg::out_trigger_only;
    cfg.depth_log2 = 4'h2;
    run(40, 1'b1);
    chk(word_count - base, 4);
    chk(last_word.addr, 10'h003);
    chk(windows_filled, 1);
    chk(out_seen, 1'b1);
    repeat (10) step();
    chk(xout, 1'b0);
    cfg.trig_pos = 10'h002;
    run(40, 1'b1);
    chk(word_count - base, 4);
    cfg.trig_pos = 10'h000;
  endtask
  task t_comb();
    trig_part = 8'h03;
    for (int i = 0; i < 4; i++)
    begin
      cfg.trig_comb = latc_pkg::latc_comb_t'(i);
      run(30, i == 1 || i == 2);
      if (i == 0 || i == 3)
        halt();
    end
    trig_part = 8'h01;
    cfg.trig_comb = latc_pkg::comb_and;
  endtask
  task t_qual();
    cfg.cap_mode = latc_pkg::cap_qualified;
    cap_cmp = 8'h00;
    run(30, 1'b0);
    chk(word_count - base, 0);
    halt();
    chk(windows_filled, 0);
    cap_cmp = 8'h01;
    run(40, 1'b1);
    chk(word_count - base, 4);
    cfg.cap_mode = latc_pkg::cap_always;
  endtask
  task t_win();
    cfg.depth_log2 = 4'h1;
    cfg.wins_log2 = 4'h1;
    stall = 1'b1;
    base = word_count;
    pulse(arm_req);
    repeat (10) step();
    chk(wr_valid, 1'b1);
    stall = 1'b0;
    run(1, 1'b1);
    run(40, 1'b1);
    chk(windows_filled, 2);
    step();
    chk(mark_addr, 10'h000);
    mark_sel = 4'h1;
    repeat (2) step();
    chk(mark_addr, 10'h002);
  endtask
  task t_ext();
    latc_pkg::latc_trig_mode_t modes[3];
    modes = '{latc_pkg::external_only_mode, latc_pkg::basic_or_external_mode,
      latc_pkg::advanced_or_external_mode};
    cfg.wins_log2 = 4'h0;
    cfg.out_mode = latc_pkg::out_input_only;
    adv_prog_loaded = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      cfg.trig_mode = modes[i];
      trig_cmp = (i == 0) ? 8'h01 : 8'h00;
      out_seen = 1'b0;
      run(20, 1'b0);
      chk(out_seen, 1'b0);
      // Neighbour event; let its handshake finish before the next mode
      pulse(fire_req);
      repeat (6) step();
      chk(buffer_full, 1'b1);
      chk(windows_filled, 1);
      chk(out_seen, 1'b1);
    end
    // Loaded program result decides; output silenced
    cfg.trig_mode = latc_pkg::advanced_only_mode;
    cfg.out_mode = latc_pkg::out_disabled;
    out_seen = 1'b0;
    run(20, 1'b0);
    adv_trig = 1'b1;
    repeat (4) step();
    chk(buffer_full, 1'b1);
    chk(out_seen, 1'b0);
    adv_trig = 1'b0;
    adv_prog_loaded = 1'b0;
    cfg.out_mode = latc_pkg::out_follows_either;
    run(30, 1'b1);
    chk(out_seen, 1'b1);
  endtask
  // Watchdog over the whole sequence
  initial
  begin
    #100000;
    err_count++;
    conclude();
  end
  initial
  begin
    repeat (20) step();
    nrst = 1'b1;
    repeat (2) step();
    t_basic();
    t_comb();
    t_qual();
    t_win();
    t_ext();
    conclude();
  end
endmodule // latc_trigger_capture_test
